// [core/board_reset_pkg.sv]
// constants and types for the board reset control block
// Behaviour
// - the reset logic watches front panel, south bridge, keyboard controller and processor chipset requests and sequences power-up, hard and soft resets.
// - after supply power good rises the management power good output rises 30 to 40 ms later.
// - a front panel reset is taken by the management controller and forwarded as a hard-reset request, never straight through.
// - either hard-reset source asserts both the ISA bus reset and the PCI bus reset.
// - the ISA bus reset resets the ISA subsystem and the PCI bus reset resets every PCI agent.
// - the host bridge passes the PCI bus reset on as the processor subsystem reset.
// - keyboard soft reset and chipset init request are merged into one processor init output, either one asserting it.
package board_reset_pkg;

  // clock rate
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 20;

  // power good delay window in milliseconds
  localparam int unsigned PWRGD_MIN_MS    = 30;
  localparam int unsigned PWRGD_MAX_MS    = 40;

  // aim at the middle of the window, still within it after rounding
  localparam int unsigned PWRGD_TGT_MS    = (PWRGD_MIN_MS + PWRGD_MAX_MS) / 2;
  localparam int unsigned PWRGD_CYCLES    = PWRGD_TGT_MS * (CLK_HZ / 1000);
  localparam int unsigned PWRGD_MIN_CYC   = PWRGD_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned PWRGD_MAX_CYC   = PWRGD_MAX_MS * (CLK_HZ / 1000);

  // width of the power good delay counter
  localparam int unsigned PWRGD_CNT_W     = 21;

  // least length of a forwarded hard-reset pulse, 1 us
  localparam int unsigned HRST_PULSE_NS   = 1000;
  localparam int unsigned HRST_PULSE_CYC  = (HRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HRST_CNT_W      = 6;

  // number of synchronised pin inputs
  localparam int unsigned SYNC_W          = 5;

  // synchroniser reset levels: every pin at its idle level, supply power good low
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 5'h1a;

  // power sequencer states
  typedef enum logic [1:0] {
    PS_OFF  = 2'b00,
    PS_WAIT = 2'b01,
    PS_ON   = 2'b10
  } pwr_state_t;

endpackage

// [core/pin_sync.sv]
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned  WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // pins and synchronised levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // pin_sync

// [core/board_reset_control.sv]
// board reset control: power-up sequencing, hard reset and soft reset merging
`timescale 1ns/1ps
module board_reset_control #(
  parameter int unsigned PWRGD_DELAY = board_reset_pkg::PWRGD_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // power good
  input  wire logic supply_pwr_good,
  output logic      mgmt_pwr_good,
  // hard reset sources
  input  wire logic front_panel_reset_n,
  input  wire logic sw_hard_reset_req,
  // soft reset sources
  input  wire logic kbc_soft_reset_req_n,
  input  wire logic chipset_init_req_n,
  // reset outputs
  output logic      fp_hard_reset_req,
  output logic      isa_bus_reset_out,
  output logic      pci_bus_reset_n,
  output logic      cpu_reset_n,
  output logic      cpu_init_n
);

  import board_reset_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] sync_in;
  logic              pg_s;
  logic              fp_rst_s;
  logic              sw_rst_s;
  logic              kbc_s;
  logic              init_s;

  pin_sync #(
    .WIDTH     (SYNC_W),
    .RESET_VAL (SYNC_IDLE)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .pin_in   ({front_panel_reset_n, kbc_soft_reset_req_n, sw_hard_reset_req,
                chipset_init_req_n, supply_pwr_good}),
    .sync_out (sync_in)
  );

  // active-high request views of the synchronised inputs
  assign pg_s     = sync_in[0];
  assign init_s   = ~sync_in[1];
  assign sw_rst_s = sync_in[2];
  assign kbc_s    = ~sync_in[3];
  assign fp_rst_s = ~sync_in[4];

  // ------------------------------------------------------------
  // power-up sequencer
  // ------------------------------------------------------------
  pwr_state_t             ps_q;
  pwr_state_t             ps_d;
  logic [PWRGD_CNT_W-1:0] pg_cnt_q;
  logic [PWRGD_CNT_W-1:0] pg_cnt_d;
  logic                   pg_out_q;
  logic                   pg_out_d;

  // wait the delay after supply power good, drop at once when it falls
  always_comb begin
    ps_d     = ps_q;
    pg_cnt_d = pg_cnt_q;
    pg_out_d = pg_out_q;
    case (ps_q)
      PS_OFF: begin
        pg_out_d = 1'b0;
        pg_cnt_d = '0;
        if (pg_s) begin
          ps_d = PS_WAIT;
        end
      end
      PS_WAIT: begin
        if (!pg_s) begin
          ps_d = PS_OFF;
        end else if (pg_cnt_q == PWRGD_CNT_W'(PWRGD_DELAY - 1)) begin
          ps_d     = PS_ON;
          pg_out_d = 1'b1;
        end else begin
          pg_cnt_d = pg_cnt_q + 1'b1;
        end
      end
      PS_ON: begin
        if (!pg_s) begin
          ps_d     = PS_OFF;
          pg_out_d = 1'b0;
        end
      end
      default: begin
        ps_d     = PS_OFF;
        pg_out_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ps_q     <= PS_OFF;
      pg_cnt_q <= '0;
      pg_out_q <= 1'b0;
    end else begin
      ps_q     <= ps_d;
      pg_cnt_q <= pg_cnt_d;
      pg_out_q <= pg_out_d;
    end
  end

  // ------------------------------------------------------------
  // front panel forwarding, stretched to a least pulse
  // ------------------------------------------------------------
  logic [HRST_CNT_W-1:0] fp_cnt_q;
  logic [HRST_CNT_W-1:0] fp_cnt_d;
  logic                  fp_req_q;
  logic                  fp_req_d;

  // the button is never passed straight through; it is re-timed here
  always_comb begin
    fp_cnt_d = fp_cnt_q;
    fp_req_d = fp_req_q;
    if (fp_rst_s) begin
      fp_req_d = 1'b1;
      fp_cnt_d = HRST_CNT_W'(HRST_PULSE_CYC - 1);
    end else if (fp_cnt_q != '0) begin
      fp_cnt_d = fp_cnt_q - 1'b1;
    end else begin
      fp_req_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fp_cnt_q <= '0;
      fp_req_q <= 1'b0;
    end else begin
      fp_cnt_q <= fp_cnt_d;
      fp_req_q <= fp_req_d;
    end
  end

  // ------------------------------------------------------------
  // reset outputs
  // ------------------------------------------------------------
  logic isa_q;
  logic isa_d;
  logic pci_n_q;
  logic pci_n_d;
  logic init_n_q;
  logic init_n_d;

  // merge sources; power-down forces every reset active
  always_comb begin
    isa_d    = ~pg_out_q | fp_req_q | sw_rst_s;
    pci_n_d  = ~isa_d;
    init_n_d = ~(~pg_out_q | kbc_s | init_s);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      isa_q    <= 1'b1;
      pci_n_q  <= 1'b0;
      init_n_q <= 1'b0;
    end else begin
      isa_q    <= isa_d;
      pci_n_q  <= pci_n_d;
      init_n_q <= init_n_d;
    end
  end

  assign mgmt_pwr_good     = pg_out_q;
  assign fp_hard_reset_req = fp_req_q;
  assign isa_bus_reset_out = isa_q;
  assign pci_bus_reset_n   = pci_n_q;
  assign cpu_reset_n       = pci_n_q;
  assign cpu_init_n        = init_n_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_pg_rise;
    $rose(pg_out_q);
  endsequence

  // cycles that synchronised supply power good has stood high, for the checks
  logic [PWRGD_CNT_W:0] pg_run_q;
  logic [PWRGD_CNT_W:0] pg_run_d;

  // saturating run length, cleared as soon as supply power good drops
  always_comb begin
    pg_run_d = pg_run_q;
    if (!pg_s) begin
      pg_run_d = '0;
    end else if (pg_run_q != '1) begin
      pg_run_d = pg_run_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pg_run_q <= '0;
    end else begin
      pg_run_q <= pg_run_d;
    end
  end

  a_pwrgd_full_wait: assert property (@(posedge clk) disable iff (rst)
    s_pg_rise |-> pg_run_q >= PWRGD_DELAY)
    else $error("power good rose before the full wait");

  a_pwrgd_late: assert property (@(posedge clk) disable iff (rst)
    (pg_run_q > PWRGD_DELAY + 1) |-> pg_out_q)
    else $error("power good later than the wait");

  a_pwrgd_hold_off: assert property (@(posedge clk) disable iff (rst)
    !pg_out_q |=> (isa_q && !pci_n_q && !init_n_q))
    else $error("resets not held while power good low");

  a_pwrgd_min_wait: assert property (@(posedge clk) disable iff (rst)
    s_pg_rise |-> ps_q == PS_ON && $past(ps_q) == PS_WAIT && pg_s)
    else $error("power good rose without the wait");

  a_pwrgd_drop: assert property (@(posedge clk) disable iff (rst)
    (pg_out_q && !pg_s) |=> !pg_out_q)
    else $error("power good did not drop with supply");

  a_hard_both: assert property (@(posedge clk) disable iff (rst)
    (pg_out_q && (fp_req_q || sw_rst_s)) |=> (isa_q && !pci_n_q))
    else $error("hard reset did not reach both buses");

  a_bus_pair: assert property (@(posedge clk) disable iff (rst)
    isa_q == !pci_n_q)
    else $error("isa and pci resets disagree");

  a_cpu_follows: assert property (@(posedge clk) disable iff (rst)
    cpu_reset_n == pci_bus_reset_n)
    else $error("processor reset does not follow pci reset");

  a_init_merge: assert property (@(posedge clk) disable iff (rst)
    (kbc_s || init_s) |=> !init_n_q)
    else $error("soft reset request did not assert init");

  a_init_idle: assert property (@(posedge clk) disable iff (rst)
    (pg_out_q && !kbc_s && !init_s) |=> init_n_q)
    else $error("init asserted without a request");

  a_fp_forward: assert property (@(posedge clk) disable iff (rst)
    $rose(fp_rst_s) |=> fp_req_q ##1 isa_q)
    else $error("front panel request not forwarded");

  a_sources_seen: assert property (@(posedge clk) disable iff (rst)
    (!pg_s && ps_q == PS_ON) |=> ##1 isa_q)
    else $error("power loss not turned into reset");

endmodule // board_reset_control

// [tb/supply_model.sv]
// behavioural supply model driving the power good pin
`timescale 1ns/1ps
module supply_model #(
  parameter int unsigned STAB_CYC = 5
) (
  // clock
  input  wire logic clk,
  // supply switch and power good pin
  input  wire logic pwr_on,
  output logic      supply_pwr_good
);
  int cnt;

  // power good rises a settle time after switch on, drops at once
  always_ff @(posedge clk) begin
    if (!pwr_on) begin
      cnt             <= 0;
      supply_pwr_good <= 1'b0;
    end else if (cnt < STAB_CYC) begin
      cnt <= cnt + 1;
    end else begin
      supply_pwr_good <= 1'b1;
    end
  end
endmodule // supply_model

// [tb/testbench.sv]
// self-checking bench for the board reset control block
`timescale 1ns/1ps
module testbench;
  import board_reset_pkg::*;
  localparam int unsigned DLY = 20;
  typedef struct packed {logic sw; logic kbc; logic ci; logic isa; logic init;} row_t;
  logic clk, rst, pwr_on, supply_pwr_good, fp_n, sw_req, kbc_n, ci_n;
  logic mgmt_pwr_good, fp_req, isa, pci_n, cpu_rst_n, init_n;
  int   fail_count, num_checks, n;
  row_t rows [6] = '{5'h0d, 5'h04, 5'h08, 5'h00, 5'h1f, 5'h16};

  // ---------------------------------------------------------------
  // clock and instances
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  supply_model i_supply_model (.clk(clk), .pwr_on(pwr_on), .supply_pwr_good(supply_pwr_good));

  board_reset_control #(.PWRGD_DELAY(DLY)) i_board_reset_control (
    .clk(clk), .rst(rst), .supply_pwr_good(supply_pwr_good), .mgmt_pwr_good(mgmt_pwr_good),
    .front_panel_reset_n(fp_n), .sw_hard_reset_req(sw_req), .kbc_soft_reset_req_n(kbc_n),
    .chipset_init_req_n(ci_n), .fp_hard_reset_req(fp_req), .isa_bus_reset_out(isa),
    .pci_bus_reset_n(pci_n), .cpu_reset_n(cpu_rst_n), .cpu_init_n(init_n));

  // ---------------------------------------------------------------
  // check and report tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %b seen %b", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // resets held while waiting for management power good
  task automatic held(input string nm);
    chk({nm, "_isa"}, isa, 1'b1);
    chk({nm, "_pci"}, pci_n, 1'b0);
    chk({nm, "_init"}, init_n, 1'b0);
  endtask

  // wait for supply power good, then count cycles to management power good
  task automatic power_up();
    n = 0;
    while (supply_pwr_good !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 50) fail_count++;
    n = 0;
    while (mgmt_pwr_good !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
      if (mgmt_pwr_good !== 1'b1) held("pwrup");
    end
    if (n >= 200) fail_count++;
    repeat (3) @(posedge clk);
    #1;
    chk("pwr_out_isa", isa, 1'b0);
    chk("pwr_out_pci", pci_n, 1'b1);
    chk("pwr_out_cpu", cpu_rst_n, 1'b1);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1; pwr_on = 1'b0; fp_n = 1'b1; sw_req = 1'b0; kbc_n = 1'b1; ci_n = 1'b1;
    fail_count = 0; num_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    pwr_on <= 1'b1;
    power_up();
    chk("pg_window", n >= DLY && n <= DLY + 6, 1'b1);
    // table of hard and soft request levels
    foreach (rows[i]) begin
      @(posedge clk);
      sw_req <= rows[i].sw;
      kbc_n  <= rows[i].kbc;
      ci_n   <= rows[i].ci;
      repeat (7) @(posedge clk);
      #1;
      chk("isa", isa, rows[i].isa);
      chk("pci", pci_n, ~rows[i].isa);
      chk("cpu_rst", cpu_rst_n, ~rows[i].isa);
      chk("init", init_n, rows[i].init);
    end
    @(posedge clk);
    sw_req <= 1'b0; kbc_n <= 1'b1;
    // short front panel press is forwarded and stretched
    repeat (3) @(posedge clk);
    fp_n <= 1'b0;
    repeat (2) @(posedge clk);
    fp_n <= 1'b1;
    repeat (7) @(posedge clk);
    #1;
    chk("fp_req", fp_req, 1'b1);
    chk("fp_isa", isa, 1'b1);
    chk("fp_pci", pci_n, 1'b0);
    n = 0;
    while (fp_req === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("fp_stretch", n >= HRST_PULSE_CYC - 7 && n <= HRST_PULSE_CYC, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk("fp_end_isa", isa, 1'b0);
    // supply drop mid-run
    @(posedge clk);
    pwr_on <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("drop_pg", mgmt_pwr_good, 1'b0);
    held("drop");
    @(posedge clk);
    pwr_on <= 1'b1;
    power_up();
    // reset in mid-run restarts the sequence
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("rst_pg", mgmt_pwr_good, 1'b0);
    chk("rst_fp", fp_req, 1'b0);
    held("rst");
    @(posedge clk);
    rst <= 1'b0;
    power_up();
    results();
  end
endmodule // testbench
